// ### can_mb_pkg.sv
// constants shared by the message buffer status and control block
// assumes a 16-bit register port with word indices and a 128-word message ram
package can_mb_pkg;
    localparam int NUM_BUF = 32;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 5;
    localparam int IDX_W = 5;
    localparam int RAM_AW = 7;

    // register word indices
    localparam logic [ADDR_W-1:0] REG_FULL_LO = 5'h00;
    localparam logic [ADDR_W-1:0] REG_FULL_HI = 5'h01;
    localparam logic [ADDR_W-1:0] REG_OVF_LO = 5'h02;
    localparam logic [ADDR_W-1:0] REG_OVF_HI = 5'h03;
    localparam logic [ADDR_W-1:0] REG_CTRL_BASE = 5'h04;
    localparam logic [ADDR_W-1:0] REG_CTRL_LAST = 5'h13;
    localparam logic [DATA_W-1:0] FLAG_RESET = 16'h0000;

    // control byte fields, same layout in low and high byte
    localparam int CTRL_DIR = 7;
    localparam int CTRL_ABT = 6;
    localparam int CTRL_LARB = 5;
    localparam int CTRL_ERR = 4;
    localparam int CTRL_REQ = 3;
    localparam int CTRL_AUTO_REMOTE_REPLY_ENABLE = 2;
    localparam int CTRL_PRIO_LSB = 0;
    localparam int BYTE_W = 8;
    localparam logic [1:0] PRIO_LOWEST = 2'h0;

    // message ram words per buffer and writable-bit masks
    localparam logic [1:0] WORD_SID = 2'h0;
    localparam logic [1:0] WORD_EID = 2'h1;
    localparam logic [1:0] WORD_DLC = 2'h2;
    localparam logic [1:0] WORD_STAT = 2'h3;
    localparam logic [DATA_W-1:0] SID_MASK = 16'h1fff;
    localparam logic [DATA_W-1:0] EID_MASK = 16'h0fff;
    localparam logic [DATA_W-1:0] DLC_MASK = 16'hff1f;
    localparam logic [DATA_W-1:0] STAT_MASK = 16'h1f00;
    localparam int FILT_LSB = 8;
    localparam int SID_LSB = 2;
    localparam int SRR_BIT = 1;
    localparam int IDE_BIT = 0;
    localparam int EIDLO_LSB = 10;
    localparam int RTR_BIT = 9;
    localparam int DLC_LSB = 0;
endpackage

// ### can_message_buffer_status_ctrl.sv
// status and control of 32 can message buffers plus their identifier ram
// assumes a protocol engine on the same clock giving one-cycle event pulses
`timescale 1ns/10ps
module can_message_buffer_status_ctrl (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [can_mb_pkg::ADDR_W-1:0] wrAddr,
    input wire logic [can_mb_pkg::DATA_W-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic [can_mb_pkg::ADDR_W-1:0] rdAddr,
    input wire logic rdStrobe,
    output logic [can_mb_pkg::DATA_W-1:0] rdData,
    input wire logic [can_mb_pkg::RAM_AW-1:0] dmaAddr,
    input wire logic [can_mb_pkg::DATA_W-1:0] dmaWrData,
    input wire logic dmaWr,
    input wire logic dmaRd,
    output logic [can_mb_pkg::DATA_W-1:0] dmaRdData,
    input wire logic rxStore,
    input wire logic [can_mb_pkg::IDX_W-1:0] rxBufIdx,
    input wire logic [can_mb_pkg::IDX_W-1:0] rxFilterIdx,
    input wire logic remoteRx,
    input wire logic [can_mb_pkg::IDX_W-1:0] remoteBufIdx,
    input wire logic txDone,
    input wire logic [can_mb_pkg::IDX_W-1:0] txBufIdx,
    input wire logic txAborted,
    input wire logic txLostArb,
    input wire logic txBusErr,
    output logic [can_mb_pkg::NUM_BUF-1:0] sendPending,
    output logic [can_mb_pkg::NUM_BUF-1:0] abortRequest,
    output logic [can_mb_pkg::NUM_BUF-1:0] txDirection,
    output logic txSelValid,
    output logic [can_mb_pkg::IDX_W-1:0] txSelIdx
);
    import can_mb_pkg::*;

    logic [NUM_BUF-1:0] fullQ, fullD, ovfQ, ovfD;
    logic [NUM_BUF-1:0] dirQ, dirD, reqQ, reqD, rtrenQ, rtrenD;
    logic [NUM_BUF-1:0] abtQ, abtD, larbQ, larbD, errQ, errD, abrtQ, abrtD;
    logic [1:0] prioQ [NUM_BUF];
    logic [1:0] prioD [NUM_BUF];
    logic [BYTE_W-1:0] ctrlByte [NUM_BUF];
    logic [NUM_BUF-1:0] swSet, swAbort, hwSet, doneHit;
    logic [DATA_W-1:0] rdData_q, rdData_d, dmaRdData_q;
    logic [DATA_W-1:0] msgRam [2**RAM_AW];
    logic selValid_q, selValid_d;
    logic [IDX_W-1:0] selIdx_q, selIdx_d;
    logic [1:0] selPrio;

    // flag register decode; a write of zero clears, one keeps
    wire fullLoWr = wrStrobe && (wrAddr == REG_FULL_LO);
    wire fullHiWr = wrStrobe && (wrAddr == REG_FULL_HI);
    wire ovfLoWr = wrStrobe && (wrAddr == REG_OVF_LO);
    wire ovfHiWr = wrStrobe && (wrAddr == REG_OVF_HI);
    wire [NUM_BUF-1:0] rxOneHot = NUM_BUF'(1) << rxBufIdx;
    wire [NUM_BUF-1:0] fullSet = rxStore ? rxOneHot : '0;
    wire [NUM_BUF-1:0] ovfSet = fullSet & fullQ;
    wire [DATA_W-1:0] ones16 = '1;
    wire [NUM_BUF-1:0] fullKeep = {fullHiWr ? wrData : ones16,
                                   fullLoWr ? wrData : ones16};
    wire [NUM_BUF-1:0] ovfKeep = {ovfHiWr ? wrData : ones16,
                                  ovfLoWr ? wrData : ones16};
    // set wins over a clear landing in the same cycle
    assign fullD = (fullQ & fullKeep) | fullSet;
    assign ovfD = (ovfQ & ovfKeep) | ovfSet;

    wire txOk = !txAborted && !txLostArb && !txBusErr;

    // per-buffer control byte next state
    for (genvar i = 0; i < NUM_BUF; i++) begin : g_buf
        wire hit = wrStrobe && (wrAddr == ADDR_W'(REG_CTRL_BASE + (i / 2)));
        wire [BYTE_W-1:0] b = wrData[BYTE_W*(i%2) +: BYTE_W];
        wire setAny = swSet[i] || hwSet[i];
        assign swSet[i] = hit && b[CTRL_REQ];
        assign swAbort[i] = hit && !b[CTRL_REQ] && reqQ[i];
        assign hwSet[i] = remoteRx && (remoteBufIdx == IDX_W'(i)) && rtrenQ[i];
        assign doneHit[i] = txDone && (txBufIdx == IDX_W'(i));
        assign dirD[i] = hit ? b[CTRL_DIR] : dirQ[i];
        assign rtrenD[i] = hit ? b[CTRL_AUTO_REMOTE_REPLY_ENABLE] : rtrenQ[i];
        assign prioD[i] = hit ? b[CTRL_PRIO_LSB +: 2] : prioQ[i];
        // a request that is set outranks a completion in the same cycle
        assign reqD[i] = setAny ? 1'b1 :
                         (doneHit[i] && (txOk || txAborted)) ? 1'b0 : reqQ[i];
        assign abtD[i] = setAny ? 1'b0 : doneHit[i] ? txAborted : abtQ[i];
        assign larbD[i] = setAny ? 1'b0 : doneHit[i] ? txLostArb : larbQ[i];
        assign errD[i] = setAny ? 1'b0 : doneHit[i] ? txBusErr : errQ[i];
        assign abrtD[i] = setAny ? 1'b0 : swAbort[i] ? 1'b1 :
                          (doneHit[i] && (txOk || txAborted)) ? 1'b0 : abrtQ[i];
        assign ctrlByte[i] = {dirQ[i], abtQ[i], larbQ[i], errQ[i], reqQ[i], rtrenQ[i],
                              prioQ[i]};
    end

    // flag and control state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fullQ <= {FLAG_RESET, FLAG_RESET};
            ovfQ <= {FLAG_RESET, FLAG_RESET};
            {dirQ, reqQ, rtrenQ, abtQ, larbQ, errQ, abrtQ} <= '0;
            for (int i = 0; i < NUM_BUF; i++) prioQ[i] <= PRIO_LOWEST;
        end else if (ce) begin
            fullQ <= fullD;
            ovfQ <= ovfD;
            {dirQ, reqQ, rtrenQ} <= {dirD, reqD, rtrenD};
            {abtQ, larbQ, errQ, abrtQ} <= {abtD, larbD, errD, abrtD};
            for (int i = 0; i < NUM_BUF; i++) prioQ[i] <= prioD[i];
        end
    end

    // read decode; unmapped indices answer zero
    wire [3:0] ctrlPair = 4'(rdAddr - REG_CTRL_BASE);
    wire ctrlRange = (rdAddr >= REG_CTRL_BASE) && (rdAddr <= REG_CTRL_LAST);
    wire [DATA_W-1:0] ctrlWord = {ctrlByte[{ctrlPair, 1'b1}], ctrlByte[{ctrlPair, 1'b0}]};
    assign rdData_d = (rdAddr == REG_FULL_LO) ? fullQ[DATA_W-1:0] :
                      (rdAddr == REG_FULL_HI) ? fullQ[NUM_BUF-1:DATA_W] :
                      (rdAddr == REG_OVF_LO) ? ovfQ[DATA_W-1:0] :
                      (rdAddr == REG_OVF_HI) ? ovfQ[NUM_BUF-1:DATA_W] :
                      ctrlRange ? ctrlWord : '0;

    // read data holds only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData_q <= '0;
        end else if (ce) begin
            rdData_q <= rdStrobe ? rdData_d : '0;
        end
    end

    // highest priority pending transmit buffer, ties go to the lowest index
    always_comb begin
        selValid_d = 1'b0;
        selIdx_d = '0;
        selPrio = PRIO_LOWEST;
        for (int i = 0; i < NUM_BUF; i++) begin
            if (reqQ[i] && dirQ[i] && !abrtQ[i] && (!selValid_d || prioQ[i] > selPrio)) begin
                selValid_d = 1'b1;
                selIdx_d = IDX_W'(i);
                selPrio = prioQ[i];
            end
        end
    end

    // registered so the engine sees a stable pick, at the cost of one cycle lag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            selValid_q <= 1'b0;
            selIdx_q <= '0;
        end else if (ce) begin
            selValid_q <= selValid_d;
            selIdx_q <= selIdx_d;
        end
    end

    // message ram word masks: unimplemented bits read zero once the word has been written
    wire [1:0] dmaWord = dmaAddr[1:0];
    wire [DATA_W-1:0] dmaMask = (dmaWord == WORD_SID) ? SID_MASK :
                                (dmaWord == WORD_EID) ? EID_MASK :
                                (dmaWord == WORD_DLC) ? DLC_MASK : STAT_MASK;
    wire [RAM_AW-1:0] statAddr = {rxBufIdx, WORD_STAT};
    wire [DATA_W-1:0] statWord = DATA_W'(rxFilterIdx) << FILT_LSB;

    // identifier, length and status words sit in dma ram, not in the map
    // reserved bits are masked to zero on every write, whatever software writes
    always_ff @(posedge clk) begin
        if (ce) begin
            if (dmaWr) begin
                msgRam[dmaAddr] <= dmaWrData & dmaMask;
            end
            if (rxStore) begin
                msgRam[statAddr] <= statWord;
            end
        end
    end

    // ram contents are not reset, only the read register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dmaRdData_q <= '0;
        end else if (ce && dmaRd) begin
            dmaRdData_q <= msgRam[dmaAddr];
        end
    end

    assign rdData = rdData_q;
    assign dmaRdData = dmaRdData_q;
    assign sendPending = reqQ;
    assign abortRequest = abrtQ;
    assign txDirection = dirQ;
    assign txSelValid = selValid_q;
    assign txSelIdx = selIdx_q;

    // checks on the flag and control behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_store;
        ce && rxStore;
    endsequence

    sequence s_full_rd;
        ce && rdStrobe && (rdAddr == REG_FULL_HI) ##1 1'b1;
    endsequence

    property p_full_set;
        s_store |=> fullQ[$past(rxBufIdx)];
    endproperty
    a_full_set: assert property (p_full_set) else $error("full flag not set");

    property p_full_clr;
        ce && fullLoWr && !wrData[0] && !(rxStore && rxBufIdx == 5'h00) |=> !fullQ[0];
    endproperty
    a_full_clr: assert property (p_full_clr) else $error("full flag not cleared");

    property p_ovf_set;
        s_store ##0 fullQ[rxBufIdx] |=> ovfQ[$past(rxBufIdx)];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag missed");

    property p_ovf_sticky;
        ovfQ[1] && !(ovfLoWr && !wrData[1]) |=> ovfQ[1];
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow lost");

    property p_full_rd;
        s_full_rd |-> rdData == $past(fullQ[NUM_BUF-1:DATA_W]);
    endproperty
    a_full_rd: assert property (p_full_rd) else $error("high full word wrong");

    property p_req_clears;
        $rose(reqQ[0]) |-> !abtQ[0] && !larbQ[0] && !errQ[0];
    endproperty
    a_req_clears: assert property (p_req_clears) else $error("status kept");

    property p_done_ok;
        ce && doneHit[0] && txOk && !swSet[0] && !hwSet[0] |=> !reqQ[0] && !abtQ[0];
    endproperty
    a_done_ok: assert property (p_done_ok) else $error("request not cleared");

    property p_abort;
        ce && swAbort[3] && !doneHit[3] && !hwSet[3] |=> abortRequest[3] && reqQ[3];
    endproperty
    a_abort: assert property (p_abort) else $error("abort not raised");

    property p_remote;
        ce && remoteRx && remoteBufIdx == 5'h03 && rtrenQ[3] |=> reqQ[3];
    endproperty
    a_remote: assert property (p_remote) else $error("remote reply lost");

    property p_prio;
        ce && selValid_d && reqQ[1] && dirQ[1] && !abrtQ[1] |=>
            prioQ[selIdx_q] >= $past(prioQ[1]) || !$stable(prioQ[selIdx_q]);
    endproperty
    a_prio: assert property (p_prio) else $error("lower priority picked");

    property p_filter;
        s_store ##0 !(dmaWr && dmaAddr == statAddr) |=> ce && dmaRd && dmaAddr ==
            $past(statAddr) |=> dmaRdData[12:8] == $past(rxFilterIdx, 2);
    endproperty
    a_filter: assert property (p_filter) else $error("filter index wrong");

    // ram reads of the identifier and length words; unimplemented bits must come back zero
    sequence s_sid_rd;
        ce && dmaRd && (dmaAddr[1:0] == WORD_SID) ##1 1'b1;
    endsequence

    sequence s_eid_rd;
        ce && dmaRd && (dmaAddr[1:0] == WORD_EID) ##1 1'b1;
    endsequence

    sequence s_dlc_rd;
        ce && dmaRd && (dmaAddr[1:0] == WORD_DLC) ##1 1'b1;
    endsequence

    property p_sid_zero;
        s_sid_rd |-> (dmaRdData & ~SID_MASK) == '0;
    endproperty
    a_sid_zero: assert property (p_sid_zero) else $error("identifier top bits set");

    property p_eid_zero;
        s_eid_rd |-> (dmaRdData & ~EID_MASK) == '0;
    endproperty
    a_eid_zero: assert property (p_eid_zero) else $error("extended top bits set");

    property p_dlc_zero;
        s_dlc_rd |-> (dmaRdData & ~DLC_MASK) == '0;
    endproperty
    a_dlc_zero: assert property (p_dlc_zero) else $error("length gap bits set");

    property p_rd_idle;
        ce && !rdStrobe |=> rdData == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");

    property p_dir_wr;
        ce && wrStrobe && (wrAddr == REG_CTRL_BASE + 5'h01) |=>
            txDirection[3] == $past(wrData[BYTE_W + CTRL_DIR]);
    endproperty
    a_dir_wr: assert property (p_dir_wr) else $error("direction not taken");

    property p_lost_arb;
        ce && doneHit[3] && txLostArb && !txAborted && !swSet[3] && !hwSet[3] |=>
            larbQ[3] && reqQ[3];
    endproperty
    a_lost_arb: assert property (p_lost_arb) else $error("lost arbitration missed");

    property p_bus_err;
        ce && doneHit[3] && txBusErr && !txAborted && !swSet[3] && !hwSet[3] |=>
            errQ[3] && reqQ[3];
    endproperty
    a_bus_err: assert property (p_bus_err) else $error("bus error missed");

    property p_aborted;
        ce && doneHit[3] && txAborted && !swSet[3] && !hwSet[3] |=>
            abtQ[3] && !reqQ[3] && !abortRequest[3];
    endproperty
    a_aborted: assert property (p_aborted) else $error("abort outcome wrong");

    property p_remote_off;
        ce && remoteRx && (remoteBufIdx == 5'h03) && !rtrenQ[3] && !swSet[3] && !doneHit[3]
            |=> reqQ[3] == $past(reqQ[3]);
    endproperty
    a_remote_off: assert property (p_remote_off) else $error("request moved");

    property p_sel_none;
        ce && !(|(reqQ & dirQ & ~abrtQ)) |=> !txSelValid;
    endproperty
    a_sel_none: assert property (p_sel_none) else $error("pick without request");

    property p_freeze;
        !ce |=> $stable(fullQ) && $stable(ovfQ) && $stable(reqQ);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule

// ### can_engine_model.sv
// stand-in for the can protocol engine and the bus beyond it
// assumes the block samples one-cycle event pulses on the rising edge
`timescale 1ns/10ps
module can_engine_model (
    input wire logic clk,
    output logic rxStore,
    output logic [can_mb_pkg::IDX_W-1:0] rxBufIdx,
    output logic [can_mb_pkg::IDX_W-1:0] rxFilterIdx,
    output logic remoteRx,
    output logic [can_mb_pkg::IDX_W-1:0] remoteBufIdx,
    output logic txDone,
    output logic [can_mb_pkg::IDX_W-1:0] txBufIdx,
    output logic txAborted,
    output logic txLostArb,
    output logic txBusErr
);
    import can_mb_pkg::*;
    // quiet bus at time zero
    initial begin
        {rxStore, remoteRx, txDone, txAborted, txLostArb, txBusErr} = '0;
        {rxBufIdx, rxFilterIdx, remoteBufIdx, txBufIdx} = '0;
    end
    // kind 0 stored frame, 1 remote frame, 2 end of transmit attempt
    // a random gap first, since a real bus answers early or late
    task automatic ev(input int kind, input logic [IDX_W-1:0] idx,
                      input logic [IDX_W-1:0] filt, input logic [2:0] fl);
        repeat (1 + $urandom % 3) @(posedge clk);
        rxStore <= (kind == 0);
        remoteRx <= (kind == 1);
        txDone <= (kind == 2);
        {rxBufIdx, remoteBufIdx, txBufIdx, rxFilterIdx} <= {idx, idx, idx, filt};
        {txAborted, txLostArb, txBusErr} <= fl;
        @(posedge clk);
        {rxStore, remoteRx, txDone} <= 3'b000;
        // stale qualifiers flipped so nothing can lean on them
        {rxBufIdx, remoteBufIdx, txBufIdx, rxFilterIdx} <= ~{idx, idx, idx, filt};
        {txAborted, txLostArb, txBusErr} <= ~fl;
    endtask
endmodule

// ### can_message_buffer_status_ctrl_tb_top.sv
// self-checking bench for the message buffer status and control block
// assumes one 40 MHz clock and the engine stand-in on the event ports
`timescale 1ns/10ps
module can_message_buffer_status_ctrl_tb_top;
    import can_mb_pkg::*;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic ce = 1'b1;
    logic wrStrobe = 1'b0, rdStrobe = 1'b0, dmaWr = 1'b0, dmaRd = 1'b0;
    logic [ADDR_W-1:0] wrAddr = '0, rdAddr = '0;
    logic [DATA_W-1:0] wrData = '0, dmaWrData = '0, rdData, dmaRdData;
    logic [RAM_AW-1:0] dmaAddr = '0;
    logic rxStore, remoteRx, txDone, txAborted, txLostArb, txBusErr, txSelValid;
    logic [IDX_W-1:0] rxBufIdx, rxFilterIdx, remoteBufIdx, txBufIdx, txSelIdx;
    logic [NUM_BUF-1:0] sendPending, abortRequest, txDirection;
    logic [NUM_BUF-1:0] fullM = '0, ovfM = '0;
    int miscompares = 0, totalChecks = 0;

    always #12.5 clk = ~clk;

    can_message_buffer_status_ctrl dut (.clk(clk), .sys_rst(sysRst), .ce(ce),
        .wrAddr(wrAddr), .wrData(wrData), .wrStrobe(wrStrobe), .rdAddr(rdAddr),
        .rdStrobe(rdStrobe), .rdData(rdData), .dmaAddr(dmaAddr), .dmaWrData(dmaWrData),
        .dmaWr(dmaWr), .dmaRd(dmaRd), .dmaRdData(dmaRdData), .rxStore(rxStore),
        .rxBufIdx(rxBufIdx), .rxFilterIdx(rxFilterIdx), .remoteRx(remoteRx),
        .remoteBufIdx(remoteBufIdx), .txDone(txDone), .txBufIdx(txBufIdx),
        .txAborted(txAborted), .txLostArb(txLostArb), .txBusErr(txBusErr),
        .sendPending(sendPending), .abortRequest(abortRequest),
        .txDirection(txDirection), .txSelValid(txSelValid), .txSelIdx(txSelIdx));
    can_engine_model eng (.clk(clk), .rxStore(rxStore), .rxBufIdx(rxBufIdx),
        .rxFilterIdx(rxFilterIdx), .remoteRx(remoteRx), .remoteBufIdx(remoteBufIdx),
        .txDone(txDone), .txBufIdx(txBufIdx), .txAborted(txAborted),
        .txLostArb(txLostArb), .txBusErr(txBusErr));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle strobes, driven just after an edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        {wrAddr, wrData, wrStrobe} <= {a, d, 1'b1};
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk);
        {rdAddr, rdStrobe} <= {a, 1'b1};
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1 chk(rdData, e);
    endtask
    task automatic dw(input logic [RAM_AW-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        {dmaAddr, dmaWrData, dmaWr} <= {a, d, 1'b1};
        @(posedge clk);
        dmaWr <= 1'b0;
    endtask
    task automatic drc(input logic [RAM_AW-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk);
        {dmaAddr, dmaRd} <= {a, 1'b1};
        @(posedge clk);
        dmaRd <= 1'b0;
        #1 chk(dmaRdData, e);
    endtask
    // flag word j as the model holds it
    function automatic logic [15:0] flagWord(int j);
        return 16'(((j < 2) ? fullM : ovfM) >> (16 * (j % 2)));
    endfunction
    // bits that survive a message ram write, for the identifier and length words only
    function automatic logic [15:0] ramMask(logic [1:0] w);
        return (w == 2'h0) ? 16'h1fff : (w == 2'h1) ? 16'h0fff : 16'hff1f;
    endfunction
    task automatic wrap_up();
        if (miscompares == 0 && totalChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog, far beyond the under a thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        wrap_up();
    end

    initial begin
        logic [RAM_AW-1:0] a;
        logic [15:0] d, w;
        logic [31:0] clr;
        logic [15:0] prio [4];
        logic [7:0] p;
        int k, b, i, j;
        prio = '{16'h8b89, 16'h888b, 16'h8b8b, 16'h8a89};
        void'($urandom(32'h6019_aec0));
        repeat (16) @(posedge clk);
        sysRst <= 1'b0;
        // reset state, with a write to the unmapped index ignored
        wr(5'h14, 16'hffff);
        for (int n = 0; n <= 20; n++) rdc(5'(n), 16'h0000);
        // priority codes, ties going to the lower buffer
        for (int n = 0; n < 4; n++) begin
            wr(5'h05, prio[n]);
            rdc(5'h05, prio[n]);
            chk({txSelValid, txSelIdx}, (n % 3 == 0) ? 6'h23 : 6'h22);
        end
        eng.ev(2, 5'd2, 5'd0, 3'b000);
        eng.ev(2, 5'd3, 5'd0, 3'b000);
        rdc(5'h05, 16'h8281);
        chk({txSelValid, sendPending[3:2]}, 3'b000);
        // full and overflow flags on a few buffers in both halves
        for (int n = 0; n < 24; n++) begin
            i = $urandom & 32'h13;
            if (n % 3 == 2) begin
                j = $urandom % 4;
                w = 16'($urandom);
                wr(5'(j), w);
                clr = {16'h0000, ~w} << (16 * (j % 2));
                if (j < 2) fullM &= ~clr;
                else ovfM &= ~clr;
            end else begin
                k = $urandom % 32;
                eng.ev(0, 5'(i), 5'(k), 3'b000);
                ovfM |= fullM & (32'h1 << i);
                fullM |= 32'h1 << i;
                drc({5'(i), WORD_STAT}, {3'h0, 5'(k), 8'h00});
            end
            for (int m = 0; m < 4; m++) rdc(5'(m), flagWord(m));
        end
        // clock enable low: a clearing write must be ignored
        @(posedge clk);
        ce <= 1'b0;
        wr(REG_FULL_LO, 16'h0000);
        ce <= 1'b1;
        rdc(REG_FULL_LO, flagWord(0));
        // transmit outcome bits on odd buffers, high byte of the pair
        for (int n = 0; n < 2; n++) begin
            k = (n == 0) ? 1 : $urandom % 16;
            b = 2 * k + 1;
            p = 8'($urandom % 4);
            wr(REG_CTRL_BASE + 5'(k), {8'h88 | p, 8'h00});
            rdc(REG_CTRL_BASE + 5'(k), {8'h88 | p, 8'h00});
            chk({sendPending[b], txDirection[b]}, 2'b11);
            eng.ev(2, 5'(b), 5'd0, 3'b010);
            rdc(REG_CTRL_BASE + 5'(k), {8'ha8 | p, 8'h00});
            wr(REG_CTRL_BASE + 5'(k), {8'h88 | p, 8'h00});
            rdc(REG_CTRL_BASE + 5'(k), {8'h88 | p, 8'h00});
            eng.ev(2, 5'(b), 5'd0, 3'b001);
            rdc(REG_CTRL_BASE + 5'(k), {8'h98 | p, 8'h00});
            wr(REG_CTRL_BASE + 5'(k), {8'h80 | p, 8'h00});
            @(negedge clk);
            chk({sendPending[b], abortRequest[b]}, 2'b11);
            eng.ev(2, 5'(b), 5'd0, 3'b100);
            rdc(REG_CTRL_BASE + 5'(k), {8'hc0 | p, 8'h00});
            chk({sendPending[b], abortRequest[b]}, 2'b00);
            wr(REG_CTRL_BASE + 5'(k), {8'h88 | p, 8'h00});
            eng.ev(2, 5'(b), 5'd0, 3'b000);
            rdc(REG_CTRL_BASE + 5'(k), {8'h80 | p, 8'h00});
            eng.ev(1, 5'(b), 5'd0, 3'b000);
            rdc(REG_CTRL_BASE + 5'(k), {8'h80 | p, 8'h00});
            wr(REG_CTRL_BASE + 5'(k), {8'h84 | p, 8'h00});
            eng.ev(1, 5'(b), 5'd0, 3'b000);
            rdc(REG_CTRL_BASE + 5'(k), {8'h8c | p, 8'h00});
            eng.ev(2, 5'(b), 5'd0, 3'b000);
            @(negedge clk);
            chk(sendPending, 32'h0000_0000);
        end
        // identifier and length words keep only their defined bits
        for (int n = 0; n < 12; n++) begin
            a = {5'($urandom), 2'($urandom % 3)};
            d = 16'($urandom);
            if (a[1:0] == WORD_DLC) d = d & 16'hfeef;
            dw(a, d);
            drc(a, d & ramMask(a[1:0]));
        end
        wrap_up();
    end
endmodule
